// [design/vsd_pkg.sv]
// package for the sampler state decoder: offsets, field positions, states
// assumes one 100 MHz core clock and an apb master of 32-bit words
//
// Contract
// - with keying on and 10-bit texels, compare only the upper 8 bits
// - keyed sharpen messages always use the replace_black_key_filter
// - key index bits 17:16 pick one of four keys; ignored when keying off
// - dword 0 bits 7:0 is the previous frame's global noise estimate
// - extended_sharpen_state address is dynamic base plus dword 1 bits 31:5
// - strong edge when edge_measure exceeds the 6-bit threshold at 13:8
// - weak edge when edge_measure lies strictly between weak and strong
// - dword 3 bit 31 set gives 3x3 smoothing, clear gives 5x5 detail
// - strong-edge pixels use the weight at bits 30:28
// - weak-edge pixels use the weight at bits 26:24
// - pixels with no edge use the weight at bits 22:20
// - overall strength is scaled by the 6-bit gain at bits 19:14
// - deinterlace entries: 8 max, 32-byte aligned, 8 dwords, index/2
// - denoise history rises by the increment at bits 11:8
// - sharing bit 14 clear: one walker, stride ignored; set: two walkers
// - stride code 13:12 gives 1,2,4,8 blocks; offset height,1,2,4
// - walker block is 4x4 with deinterlacing, 4x8 for denoising only
// - divisor bias is bits 15:13 plus one, range 1 to 8
// - block is moving when moving-pixel count passes bits 12:8
// - shift down 4,5,6 by bits 23:22; shift up 6,7 by bits 21:20, of which only bit 20 is read
package vsd_pkg;
  // apb byte offsets
  localparam logic [7:0] A_DYN    = 8'h00;
  localparam logic [7:0] A_SHBASE = 8'h04;
  localparam logic [7:0] A_DIBASE = 8'h08;
  localparam logic [7:0] A_STAT   = 8'h0c;
  localparam logic [7:0] A_KEY0   = 8'h10;
  localparam int         NKEY     = 4;
  localparam int         ALIGN    = 5;
  localparam int         SH_NDW   = 4;
  localparam int         DI_NDW   = 8;
  localparam int         SH_STEP  = 4;
  localparam int         DI_STEP  = 5;
  // sharpen entry fields
  localparam int KEY_EN_B = 18;
  localparam int KEY_IX_L = 16;
  localparam int NOISE_L  = 0;
  localparam int STRONG_L = 8;
  localparam int WEAK_L   = 0;
  localparam int SMOOTH_B = 31;
  localparam int WS_L     = 28;
  localparam int WR_L     = 24;
  localparam int WN_L     = 20;
  localparam int GAIN_L   = 14;
  // deinterlace entry fields
  localparam int SHARE_B  = 14;
  localparam int STRIDE_L = 12;
  localparam int HDELTA_L = 8;
  localparam int C2_L     = 13;
  localparam int MOVE_L   = 8;
  localparam int SHIFT_DW = 4;
  localparam int SDN_L    = 22;
  localparam int SUP_L    = 20;
  localparam logic [2:0] SDN_BASE = 3'h4;
  localparam logic [2:0] SUP_BASE = 3'h6;
  localparam logic [1:0] SDN_RSVD = 2'h3;
  localparam logic [3:0] ROWS_DI  = 4'h4;
  localparam logic [3:0] ROWS_DN  = 4'h8;
  localparam logic [2:0] SPAN_SM  = 3'h3;
  localparam logic [2:0] SPAN_DT  = 3'h5;
  localparam logic [1:0] CL_NONE   = 2'h0;
  localparam logic [1:0] CL_WEAK   = 2'h1;
  localparam logic [1:0] CL_STRONG = 2'h2;
  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_DECODE} vsd_state_type;
endpackage

// [design/vsd_top.sv]
// sampler state decoder: fetches a state entry and decodes its fields
// assumes a memory port answering one dword per MEM_ACK, same clock
`timescale 1ns/100ps
module vsd_top (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        MSG_VALID,
  input  wire logic        MSG_DEINT,
  input  wire logic [3:0]  MSG_INDEX,
  input  wire logic        MSG_DI_EN,
  output logic             MSG_READY,
  output logic             MEM_REQ,
  output logic      [31:0] MEM_ADDR,
  input  wire logic        MEM_ACK,
  input  wire logic [31:0] MEM_RDATA,
  output logic             ST_VALID,
  output logic             KEY_BLACK,
  output logic      [7:0]  NOISE_EST,
  output logic      [31:0] XSTATE_ADDR,
  output logic      [2:0]  FILTER_SPAN,
  output logic             SMOOTH_MODE,
  output logic      [5:0]  GAIN,
  output logic             TWO_WALKERS,
  output logic      [3:0]  STRIDE_BLK,
  output logic      [2:0]  OFFSET_BLK,
  output logic             OFFSET_HEIGHT,
  output logic      [3:0]  BLOCK_ROWS,
  output logic      [3:0]  HIST_DELTA,
  output logic      [3:0]  DIV_BIAS,
  output logic      [2:0]  SHIFT_DN,
  output logic      [2:0]  SHIFT_UP,
  output logic             SHIFT_RSVD,
  input  wire logic        PIX_VALID,
  input  wire logic [7:0]  PIX_EM,
  input  wire logic [29:0] PIX_TEXEL,
  input  wire logic        PIX_TEN_BIT,
  input  wire logic [4:0]  MOVE_COUNT,
  output logic             PIX_OUT_VALID,
  output logic      [1:0]  PIX_CLASS,
  output logic      [2:0]  PIX_STRENGTH,
  output logic             PIX_KEY_HIT,
  output logic             BLOCK_MOVING
);
  vsd_pkg::vsd_state_type st_r;
  logic [31:0] ent_r [0:vsd_pkg::DI_NDW-1];
  logic [2:0]  cnt_r;
  logic        deint_r;
  logic        di_en_r;
  logic [31:0] dyn_r;
  logic [31:0] shb_r;
  logic [31:0] dib_r;
  logic [23:0] key_r [0:vsd_pkg::NKEY-1];
  logic        ready_r;
  logic [31:0] rdata_r;
  logic        err_r;
  logic        req_r;
  logic [31:0] addr_r;
  logic        stv_r;
  logic [2:0]  last_w;
  logic [31:0] rd_w;
  logic        hit_w;
  logic        take_w;
  logic        msg_rdy_r;
  // decoded fields held for the pixel path
  logic        key_en_r;
  logic [1:0]  key_ix_r;
  logic [5:0]  strong_r;
  logic [5:0]  weak_r;
  logic [2:0]  ws_r;
  logic [2:0]  wr_r;
  logic [2:0]  wn_r;
  logic [4:0]  move_r;
  logic [2:0]  ch_eq_w;

  assign last_w = deint_r ? 3'(vsd_pkg::DI_NDW - 1) : 3'(vsd_pkg::SH_NDW - 1);
  assign take_w = MSG_VALID && msg_rdy_r; // ready is only high while idle

  // apb read mux and decode; unmapped offsets answer with pslverr
  always_comb begin
    rd_w  = '0;
    hit_w = 1'b1;
    unique case (PADDR)
      vsd_pkg::A_DYN:    rd_w = dyn_r;
      vsd_pkg::A_SHBASE: rd_w = shb_r;
      vsd_pkg::A_DIBASE: rd_w = dib_r;
      vsd_pkg::A_STAT:   rd_w = {28'h0, di_en_r, deint_r, stv_r, st_r != vsd_pkg::S_IDLE};
      default: begin
        if (PADDR[7:4] == vsd_pkg::A_KEY0[7:4] && PADDR[1:0] == 2'h0) begin
          rd_w = {8'h00, key_r[PADDR[3:2]]};
        end else begin
          hit_w = 1'b0;
        end
      end
    endcase
  end

  // one wait state: pready rises the cycle after the access phase begins
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ready_r <= 1'b0;
      rdata_r <= '0;
      err_r   <= 1'b0;
    end else if (PSEL && PENABLE && !ready_r) begin
      ready_r <= 1'b1;
      rdata_r <= PWRITE ? 32'h0 : rd_w;
      err_r   <= !hit_w;
    end else begin
      ready_r <= 1'b0;
      err_r   <= 1'b0;
    end
  end

  // base registers; the low five bits of the sharpen and deinterlace bases are forced to zero for alignment
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dyn_r <= '0;
      shb_r <= '0;
      dib_r <= '0;
    end else if (PSEL && PENABLE && ready_r && PWRITE) begin
      if (PADDR == vsd_pkg::A_DYN) dyn_r <= PWDATA;
      if (PADDR == vsd_pkg::A_SHBASE) shb_r <= {PWDATA[31:vsd_pkg::ALIGN], 5'h00};
      if (PADDR == vsd_pkg::A_DIBASE) dib_r <= {PWDATA[31:vsd_pkg::ALIGN], 5'h00};
    end
  end

  // key table, one 24-bit key per entry
  for (genvar k = 0; k < vsd_pkg::NKEY; k++) begin : g_key
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
        key_r[k] <= '0;
      end else if (PSEL && PENABLE && ready_r && PWRITE && hit_w &&
                   PADDR[7:4] == vsd_pkg::A_KEY0[7:4] && PADDR[3:2] == 2'(k)) begin
        key_r[k] <= PWDATA[23:0];
      end
    end
  end

  // fetch sequencer: a message is taken only while idle
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r    <= vsd_pkg::S_IDLE;
      cnt_r   <= '0;
      req_r   <= 1'b0;
      addr_r  <= '0;
      deint_r <= 1'b0;
      di_en_r <= 1'b0;
    end else begin
      unique case (st_r)
        vsd_pkg::S_IDLE: begin
          if (take_w) begin
            st_r    <= vsd_pkg::S_FETCH;
            cnt_r   <= '0;
            req_r   <= 1'b1;
            deint_r <= MSG_DEINT;
            di_en_r <= MSG_DI_EN;
            // deinterlace entries are 8 dwords apart, selected by index/2
            addr_r  <= MSG_DEINT ? dib_r + 32'({MSG_INDEX[3:1], 5'h00})
                                 : shb_r + 32'({MSG_INDEX, 4'h0});
          end
        end
        vsd_pkg::S_FETCH: begin
          if (MEM_ACK) begin
            cnt_r  <= cnt_r + 3'h1;
            addr_r <= addr_r + 32'h4;
            if (cnt_r == last_w) begin
              req_r <= 1'b0;
              st_r  <= vsd_pkg::S_DECODE;
            end
          end
        end
        vsd_pkg::S_DECODE: st_r <= vsd_pkg::S_IDLE;
      endcase
    end
  end

  // entry storage, written per dword as it arrives
  for (genvar i = 0; i < vsd_pkg::DI_NDW; i++) begin : g_ent
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
        ent_r[i] <= '0;
      end else if (st_r == vsd_pkg::S_FETCH && MEM_ACK && cnt_r == 3'(i)) begin
        ent_r[i] <= MEM_RDATA;
      end
    end
  end

  // sharpen decode, only from a complete entry
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      key_en_r    <= 1'b0;
      key_ix_r    <= '0;
      KEY_BLACK   <= 1'b0;
      NOISE_EST   <= '0;
      XSTATE_ADDR <= '0;
      strong_r    <= '0;
      weak_r      <= '0;
      SMOOTH_MODE <= 1'b0;
      FILTER_SPAN <= vsd_pkg::SPAN_DT;
      ws_r        <= '0;
      wr_r        <= '0;
      wn_r        <= '0;
      GAIN        <= '0;
    end else if (st_r == vsd_pkg::S_DECODE && !deint_r) begin
      key_en_r    <= ent_r[0][vsd_pkg::KEY_EN_B];
      key_ix_r    <= ent_r[0][vsd_pkg::KEY_IX_L +: 2];
      KEY_BLACK   <= ent_r[0][vsd_pkg::KEY_EN_B];
      NOISE_EST   <= ent_r[0][vsd_pkg::NOISE_L +: 8];
      XSTATE_ADDR <= dyn_r + {ent_r[1][31:vsd_pkg::ALIGN], 5'h00};
      strong_r    <= ent_r[2][vsd_pkg::STRONG_L +: 6];
      weak_r      <= ent_r[2][vsd_pkg::WEAK_L +: 6];
      SMOOTH_MODE <= ent_r[3][vsd_pkg::SMOOTH_B];
      FILTER_SPAN <= ent_r[3][vsd_pkg::SMOOTH_B] ? vsd_pkg::SPAN_SM : vsd_pkg::SPAN_DT;
      ws_r        <= ent_r[3][vsd_pkg::WS_L +: 3];
      wr_r        <= ent_r[3][vsd_pkg::WR_L +: 3];
      wn_r        <= ent_r[3][vsd_pkg::WN_L +: 3];
      GAIN        <= ent_r[3][vsd_pkg::GAIN_L +: 6];
    end
  end

  // deinterlace decode; the stride is ignored when one walker covers all
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      TWO_WALKERS   <= 1'b0;
      STRIDE_BLK    <= 4'h1;
      OFFSET_BLK    <= '0;
      OFFSET_HEIGHT <= 1'b0;
      BLOCK_ROWS    <= vsd_pkg::ROWS_DI;
      HIST_DELTA    <= '0;
      DIV_BIAS      <= 4'h1;
      move_r        <= '0;
      SHIFT_DN      <= vsd_pkg::SDN_BASE;
      SHIFT_UP      <= vsd_pkg::SUP_BASE;
      SHIFT_RSVD    <= 1'b0;
    end else if (st_r == vsd_pkg::S_DECODE && deint_r) begin
      TWO_WALKERS <= ent_r[0][vsd_pkg::SHARE_B];
      if (ent_r[0][vsd_pkg::SHARE_B]) begin
        STRIDE_BLK    <= 4'h1 << ent_r[0][vsd_pkg::STRIDE_L +: 2];
        OFFSET_HEIGHT <= ent_r[0][vsd_pkg::STRIDE_L +: 2] == 2'h0;
        OFFSET_BLK    <= ent_r[0][vsd_pkg::STRIDE_L +: 2] == 2'h0 ? 3'h0
                         : 3'h1 << (ent_r[0][vsd_pkg::STRIDE_L +: 2] - 2'h1);
      end else begin
        STRIDE_BLK    <= 4'h1;
        OFFSET_HEIGHT <= 1'b0;
        OFFSET_BLK    <= 3'h0;
      end
      BLOCK_ROWS <= di_en_r ? vsd_pkg::ROWS_DI : vsd_pkg::ROWS_DN;
      HIST_DELTA <= ent_r[0][vsd_pkg::HDELTA_L +: 4];
      DIV_BIAS   <= {1'b0, ent_r[1][vsd_pkg::C2_L +: 3]} + 4'h1;
      move_r     <= ent_r[1][vsd_pkg::MOVE_L +: 5];
      // reserved shift code falls back to the smallest shift and is flagged
      SHIFT_RSVD <= ent_r[vsd_pkg::SHIFT_DW][vsd_pkg::SDN_L +: 2] == vsd_pkg::SDN_RSVD;
      SHIFT_DN   <= ent_r[vsd_pkg::SHIFT_DW][vsd_pkg::SDN_L +: 2] == vsd_pkg::SDN_RSVD
                    ? vsd_pkg::SDN_BASE
                    : vsd_pkg::SDN_BASE + {1'b0, ent_r[vsd_pkg::SHIFT_DW][vsd_pkg::SDN_L +: 2]};
      SHIFT_UP   <= vsd_pkg::SUP_BASE + {2'b0, ent_r[vsd_pkg::SHIFT_DW][vsd_pkg::SUP_L]};
    end
  end

  // per-channel key compare; 10-bit texels drop their two low bits
  for (genvar c = 0; c < 3; c++) begin : g_ch
    assign ch_eq_w[c] = (PIX_TEN_BIT ? PIX_TEXEL[c*10+2 +: 8]
                                     : PIX_TEXEL[c*10 +: 8]) == key_r[key_ix_r][c*8 +: 8];
  end

  // pixel path: one cycle from PIX_VALID to PIX_OUT_VALID
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PIX_OUT_VALID <= 1'b0;
      PIX_CLASS     <= vsd_pkg::CL_NONE;
      PIX_STRENGTH  <= '0;
      PIX_KEY_HIT   <= 1'b0;
      BLOCK_MOVING  <= 1'b0;
    end else begin
      PIX_OUT_VALID <= PIX_VALID;
      if (PIX_VALID) begin
        PIX_KEY_HIT  <= key_en_r && &ch_eq_w;
        BLOCK_MOVING <= MOVE_COUNT > move_r;
        if (PIX_EM > {2'b00, strong_r}) begin
          PIX_CLASS    <= vsd_pkg::CL_STRONG;
          PIX_STRENGTH <= ws_r;
        end else if (PIX_EM > {2'b00, weak_r} && PIX_EM < {2'b00, strong_r}) begin
          PIX_CLASS    <= vsd_pkg::CL_WEAK;
          PIX_STRENGTH <= wr_r;
        end else begin
          PIX_CLASS    <= vsd_pkg::CL_NONE;
          PIX_STRENGTH <= wn_r;
        end
      end
    end
  end

  // decode strobe and port drive
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) stv_r <= 1'b0;
    else stv_r <= st_r == vsd_pkg::S_DECODE;
  end
  assign ST_VALID  = stv_r;
  assign MSG_READY = msg_rdy_r;
  // ready drops on the take edge so a held request is never taken twice
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) msg_rdy_r <= 1'b0;
    else msg_rdy_r <= (st_r == vsd_pkg::S_IDLE && !take_w) || st_r == vsd_pkg::S_DECODE;
  end
  assign MEM_REQ  = req_r;
  assign MEM_ADDR = addr_r;
  assign PREADY   = ready_r;
  assign PRDATA   = rdata_r;
  assign PSLVERR  = err_r;

  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_last_ack;
    st_r == vsd_pkg::S_FETCH && MEM_ACK && cnt_r == last_w;
  endsequence
  sequence s_sh_dec;
    st_r == vsd_pkg::S_DECODE && !deint_r;
  endsequence
  sequence s_di_dec;
    st_r == vsd_pkg::S_DECODE && deint_r;
  endsequence
  a_entry_held: assert property (s_last_ack |=> !MEM_REQ ##1 ST_VALID)
    else $error("strobe not after full entry");
  a_noise_field: assert property (s_sh_dec |=> NOISE_EST == $past(ent_r[0][7:0]))
    else $error("noise estimate wrong");
  a_xstate_addr: assert property (s_sh_dec |=> XSTATE_ADDR[4:0] == 5'h00 &&
    XSTATE_ADDR == dyn_r + {ent_r[1][31:5], 5'h00})
    else $error("extended state address wrong");
  a_strong_edge: assert property (PIX_VALID && st_r != vsd_pkg::S_DECODE &&
    PIX_EM > {2'b00, strong_r} |=> PIX_CLASS == vsd_pkg::CL_STRONG && PIX_STRENGTH == ws_r)
    else $error("strong edge missed");
  a_weak_edge: assert property (PIX_VALID && st_r != vsd_pkg::S_DECODE &&
    PIX_EM == {2'b00, strong_r} |=> PIX_CLASS == vsd_pkg::CL_NONE)
    else $error("equal measure classed as edge");
  a_key_off: assert property (PIX_VALID && !key_en_r |=> !PIX_KEY_HIT)
    else $error("key hit while keying off");
  a_deint_addr: assert property (take_w && MSG_DEINT |=>
    MEM_ADDR == dib_r + 32'({$past(MSG_INDEX[3:1]), 5'h00}) && MEM_REQ)
    else $error("deinterlace entry address wrong");
  a_single_walk: assert property (s_di_dec ##0 !ent_r[0][vsd_pkg::SHARE_B] |=>
    !TWO_WALKERS && STRIDE_BLK == 4'h1 && !OFFSET_HEIGHT)
    else $error("stride not ignored");
  a_bias_range: assert property (s_di_dec |=> DIV_BIAS >= 4'h1 && DIV_BIAS <= 4'h8)
    else $error("divisor bias out of range");
endmodule

// [test/vsd_mem_model.sv]
// memory model standing behind the decoder's state fetch port
// assumes one dword per MEM_ACK and MEM_ADDR stepping after each ack
`timescale 1ns/100ps
module vsd_mem_model (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  input  wire logic [3:0]  DELAY,
  input  wire logic        MEM_REQ,
  input  wire logic [31:0] MEM_ADDR,
  output logic             MEM_ACK,
  output logic      [31:0] MEM_RDATA
);
  logic [31:0] words [256];
  logic [3:0]  wait_r;

  // one ack per dword after DELAY idle cycles; off the ack the data toggles
  // every cycle so a decoder that samples late never sees a stale match
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      MEM_ACK   <= 1'h0;
      MEM_RDATA <= 32'h0;
      wait_r    <= 4'h0;
    end else if (MEM_REQ && !MEM_ACK && wait_r >= DELAY) begin
      MEM_ACK   <= 1'h1;
      MEM_RDATA <= words[MEM_ADDR[9:2]];
      wait_r    <= 4'h0;
    end else begin
      MEM_ACK   <= 1'h0;
      MEM_RDATA <= ~MEM_RDATA;
      wait_r    <= MEM_REQ ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

// [test/test_video_sampler_state_decode.sv]
// self-checking bench for the sampler state decoder
// assumes the memory model is compiled before this file
`timescale 1ns/100ps
module test_video_sampler_state_decode;
  localparam logic [31:0] SHB = 32'h100;
  localparam logic [31:0] DIB = 32'h200;
  localparam logic [31:0] DYN = 32'h1000_0000;
  localparam logic [29:0] T   = {10'h0c3, 10'h083, 10'h043};
  localparam logic [29:0] T2  = {10'h0c3, 10'h083, 10'h047};
  typedef struct {logic dt; logic [3:0] ix; logic de; logic [31:0] a, b, c, d;} vsd_row_type;
  typedef struct {int r; logic [7:0] em; logic [29:0] tx; logic [4:0] mc;
    logic [1:0] cl; logic [2:0] st; logic hit; logic mv;} vsd_pix_type;
  logic CORE_CLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, MSG_VALID = 0;
  logic MSG_DEINT = 0, MSG_DI_EN = 0, PIX_VALID = 0, PIX_TEN_BIT = 1;
  logic [7:0] PADDR = 8'h0, PIX_EM = 8'h0;
  logic [31:0] PWDATA = 32'h0;
  logic [3:0] MSG_INDEX = 4'h0, dly = 4'h0;
  logic [29:0] PIX_TEXEL = 30'h0;
  logic [4:0] MOVE_COUNT = 5'h0;
  logic [31:0] PRDATA, MEM_ADDR, MEM_RDATA, XSTATE_ADDR;
  logic PREADY, PSLVERR, MSG_READY, MEM_REQ, MEM_ACK, ST_VALID, KEY_BLACK, SMOOTH_MODE;
  logic TWO_WALKERS, OFFSET_HEIGHT, SHIFT_RSVD, PIX_OUT_VALID, PIX_KEY_HIT, BLOCK_MOVING;
  logic [7:0] NOISE_EST;
  logic [2:0] FILTER_SPAN, OFFSET_BLK, SHIFT_DN, SHIFT_UP, PIX_STRENGTH;
  logic [5:0] GAIN;
  logic [3:0] STRIDE_BLK, BLOCK_ROWS, HIST_DELTA, DIV_BIAS;
  logic [1:0] PIX_CLASS;
  int num_errors = 0;
  int n_tests = 0;
  // sharpen rows: dwords 0..3; deinterlace rows: dwords 0, 1, 4, filler
  // each message stands for its own primitive, so pointers may differ
  // the moving-pixel threshold, dword 1 bits 12:8, is nonzero only in deinterlace rows 2 and 3
  vsd_row_type rows [7] = '{
    '{1'h0, 4'h0, 1'h0, 32'h0006_0055, 32'h1234_56ff, 32'h0000_0801, 32'h721a_03c6},
    '{1'h0, 4'hf, 1'h0, 32'h0003_00aa, 32'hffff_ffff, 32'h0000_3f00, 32'hf000_0000},
    '{1'h1, 4'h0, 1'h1, 32'h0000_4f00, 32'h0000_e500, 32'h0000_0000, 32'h5a5a_5a5a},
    '{1'h1, 4'hf, 1'h0, 32'h0000_5100, 32'h0000_1000, 32'h0050_0000, 32'h5a5a_5a5a},
    '{1'h1, 4'h4, 1'h1, 32'h0000_6800, 32'h0000_2000, 32'h0080_0000, 32'h5a5a_5a5a},
    '{1'h1, 4'h9, 1'h0, 32'h0000_7200, 32'h0000_0000, 32'h00c0_0000, 32'h5a5a_5a5a},
    '{1'h1, 4'h2, 1'h1, 32'h0000_3300, 32'h0000_0000, 32'h0000_0000, 32'h5a5a_5a5a}};
  // pixel cases run after the row named in their first field
  vsd_pix_type pixs [11] = '{
    '{0, 8'h09, T, 5'h00, 2'h2, 3'h7, 1'h1, 1'h0}, '{0, 8'h08, T, 5'h00, 2'h0, 3'h1, 1'h1, 1'h0},
    '{0, 8'h02, T2, 5'h00, 2'h1, 3'h2, 1'h0, 1'h0}, '{0, 8'h01, T2, 5'h00, 2'h0, 3'h1, 1'h0, 1'h0},
    '{1, 8'h3f, T, 5'h00, 2'h0, 3'h0, 1'h0, 1'h0}, '{1, 8'h0a, T, 5'h00, 2'h1, 3'h0, 1'h0, 1'h0},
    '{1, 8'h40, T, 5'h00, 2'h2, 3'h7, 1'h0, 1'h0}, '{2, 8'h00, T2, 5'h05, 2'h0, 3'h0, 1'h0, 1'h0},
    '{2, 8'h00, T2, 5'h06, 2'h0, 3'h0, 1'h0, 1'h1}, '{3, 8'h00, T2, 5'h10, 2'h0, 3'h0, 1'h0, 1'h0},
    '{3, 8'h00, T2, 5'h11, 2'h0, 3'h0, 1'h0, 1'h1}};

  vsd_top dut (.CORE_CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .MSG_VALID, .MSG_DEINT, .MSG_INDEX, .MSG_DI_EN, .MSG_READY,
    .MEM_REQ, .MEM_ADDR, .MEM_ACK, .MEM_RDATA, .ST_VALID, .KEY_BLACK, .NOISE_EST,
    .XSTATE_ADDR, .FILTER_SPAN, .SMOOTH_MODE, .GAIN, .TWO_WALKERS, .STRIDE_BLK,
    .OFFSET_BLK, .OFFSET_HEIGHT, .BLOCK_ROWS, .HIST_DELTA, .DIV_BIAS, .SHIFT_DN,
    .SHIFT_UP, .SHIFT_RSVD, .PIX_VALID, .PIX_EM, .PIX_TEXEL, .PIX_TEN_BIT, .MOVE_COUNT,
    .PIX_OUT_VALID, .PIX_CLASS, .PIX_STRENGTH, .PIX_KEY_HIT, .BLOCK_MOVING);
  vsd_mem_model mem_model (.CORE_CLK, .RST_B, .DELAY(dly), .MEM_REQ, .MEM_ADDR,
    .MEM_ACK, .MEM_RDATA);

  // 100 MHz core clock
  always #5 CORE_CLK = ~CORE_CLK;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // apb transfer: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge CORE_CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'h1;
    // no cycle count assumed: only the watchdog ends this wait
    do begin
      @(posedge CORE_CLK);
    end while (PREADY !== 1'h1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask

  // message held until taken, then fetch watched until the decode pulse
  task automatic msg(input vsd_row_type r, input logic [31:0] base);
    int n;
    int acks;
    logic got;
    @(posedge CORE_CLK);
    MSG_VALID <= 1'h1;
    MSG_DEINT <= r.dt;
    MSG_INDEX <= r.ix;
    MSG_DI_EN <= r.de;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (MSG_READY !== 1'h1 && n < 50);
    MSG_VALID <= 1'h0;
    acks = 0;
    got = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
      if (MEM_REQ === 1'h1 && !got) begin
        chk("mem_addr", base, MEM_ADDR);
        got = 1;
      end
      if (MEM_ACK === 1'h1) acks++;
    end while (ST_VALID !== 1'h1 && n < 200);
    chk("st_valid", 1, ST_VALID);
    chk("dwords", r.dt ? 8 : 4, acks);
  endtask

  task automatic pix(input vsd_pix_type p);
    @(posedge CORE_CLK);
    PIX_VALID <= 1'h1;
    PIX_EM <= p.em;
    PIX_TEXEL <= p.tx;
    MOVE_COUNT <= p.mc;
    @(posedge CORE_CLK);
    PIX_VALID <= 1'h0;
    @(posedge CORE_CLK);
    chk("pix_valid", 1, PIX_OUT_VALID);
    chk("class", p.cl, PIX_CLASS);
    chk("strength", p.st, PIX_STRENGTH);
    chk("key_hit", p.hit, PIX_KEY_HIT);
    chk("moving", p.mv, BLOCK_MOVING);
  endtask

  // defaults that every reset must restore
  task automatic rst_chk();
    chk("span_rst", 5, FILTER_SPAN);
    chk("stride_rst", 1, STRIDE_BLK);
    chk("rows_rst", 4, BLOCK_ROWS);
    chk("bias_rst", 1, DIV_BIAS);
    chk("sdn_rst", 4, SHIFT_DN);
    chk("sup_rst", 6, SHIFT_UP);
    chk("ready_rst", 0, MSG_READY);
  endtask

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge CORE_CLK);
    num_errors++;
    results();
  end

  // main sequence: setup, table of rows, then the awkward cases
  initial begin
    vsd_row_type r;
    logic [31:0] ent [8];
    logic [31:0] base;
    logic [31:0] rdv;
    logic erv;
    logic sh;
    logic [1:0] s;
    repeat (10) @(posedge CORE_CLK);
    rst_chk();
    RST_B <= 1'h1;
    apb(1'h1, vsd_pkg::A_DYN, DYN, rdv, erv);
    apb(1'h1, vsd_pkg::A_SHBASE, SHB, rdv, erv);
    apb(1'h1, vsd_pkg::A_DIBASE, DIB | 32'h13, rdv, erv);
    apb(1'h0, vsd_pkg::A_DIBASE, 32'h0, rdv, erv);
    chk("di_base", DIB, rdv);
    apb(1'h1, vsd_pkg::A_KEY0 | 8'h08, 32'h0030_2010, rdv, erv);
    apb(1'h1, vsd_pkg::A_KEY0 | 8'h0c, 32'h0030_2010, rdv, erv);
    apb(1'h0, vsd_pkg::A_KEY0 | 8'h08, 32'h0, rdv, erv);
    chk("key_rd", 32'h0030_2010, rdv);
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      dly <= (i % 2) ? 4'h3 : 4'h0;
      ent = '{r.a, r.b, r.c, r.d, r.d, r.d, r.d, r.d};
      if (r.dt) begin
        ent[2] = r.d;
        ent[4] = r.c;
      end
      base = r.dt ? DIB + (r.ix >> 1) * 32 : SHB + r.ix * 16;
      for (int k = 0; k < 8; k++) mem_model.words[base[9:2] + k] = ent[k];
      msg(r, base);
      sh = r.a[14];
      s = r.a[13:12];
      if (!r.dt) begin
        chk("key_black", r.a[18], KEY_BLACK);
        chk("noise", r.a[7:0], NOISE_EST);
        chk("xstate", DYN + {r.b[31:5], 5'h0}, XSTATE_ADDR);
        chk("smooth", r.d[31], SMOOTH_MODE);
        chk("span", r.d[31] ? 3 : 5, FILTER_SPAN);
        chk("gain", r.d[19:14], GAIN);
      end else begin
        chk("two_walk", sh, TWO_WALKERS);
        chk("stride", sh ? 1 << s : 1, STRIDE_BLK);
        chk("off_blk", (sh && s != 0) ? 1 << (s - 1) : 0, OFFSET_BLK);
        chk("off_ht", sh && s == 0, OFFSET_HEIGHT);
        chk("hist", r.a[11:8], HIST_DELTA);
        chk("rows", r.de ? 4 : 8, BLOCK_ROWS);
        chk("bias", r.b[15:13] + 1, DIV_BIAS);
        chk("sdn", r.c[23:22] == 3 ? 4 : 4 + r.c[23:22], SHIFT_DN);
        chk("rsvd", r.c[23:22] == 3, SHIFT_RSVD);
        chk("sup", 6 + r.c[20], SHIFT_UP);
      end
      for (int j = 0; j < 11; j++) begin
        if (pixs[j].r == i) pix(pixs[j]);
      end
    end
    // unmapped offset: refused on both directions, reads back zero
    apb(1'h1, 8'h40, 32'hffff_ffff, rdv, erv);
    chk("wr_err", 1, erv);
    apb(1'h0, 8'h40, 32'h0, rdv, erv);
    chk("rd_err", 1, erv);
    chk("rd_unmapped", 0, rdv);
    // 8-bit texels compare each channel's whole low byte; row 0 keys again
    msg(rows[0], SHB);
    PIX_TEN_BIT <= 1'h0;
    pix('{0, 8'h09, {10'h030, 10'h020, 10'h010}, 5'h00, 2'h2, 3'h7, 1'h1, 1'h0});
    pix('{0, 8'h09, T, 5'h00, 2'h2, 3'h7, 1'h0, 1'h0});
    // reset in mid-run must restore defaults and clear the sharpen base register
    @(posedge CORE_CLK);
    RST_B <= 1'h0;
    repeat (2) @(posedge CORE_CLK);
    rst_chk();
    RST_B <= 1'h1;
    apb(1'h0, vsd_pkg::A_SHBASE, 32'h0, rdv, erv);
    chk("shbase_rst", 0, rdv);
    apb(1'h0, vsd_pkg::A_STAT, 32'h0, rdv, erv);
    chk("stat_rst", 0, rdv);
    chk("ready_idle", 1, MSG_READY);
    results();
  end
endmodule
